// ==== hdl/hwi_status_top.sv ====
// hardware interrupt pending, enable and output enable registers, low bits
`timescale 1ns/1ps
module hwi_status_top #(
   parameter int unsigned DATA_W = hwi_pkg::HWI_DATA_W
) (
   // clock and reset
   input  wire logic                             ref_clk_in,
   input  wire logic                             rst_in,
   // device pins
   input  wire logic                             master_reset_n_in,
   input  wire logic                             term1_enable_pin_in,
   input  wire logic                             term2_enable_pin_in,
   input  wire logic [hwi_pkg::HWI_TADDR_W-1:0]  term1_addr_pins_in,
   input  wire logic [hwi_pkg::HWI_TADDR_W-1:0]  term2_addr_pins_in,
   // time tag events
   input  wire logic                             mon_tag_incr_in,
   input  wire logic [15:0]                      mon_tag_count_in,
   input  wire logic [15:0]                      mon_tag_match_value_in,
   input  wire logic                             ctl_tag_incr_in,
   input  wire logic [15:0]                      ctl_tag_count_in,
   input  wire logic [15:0]                      ctl_tag_match_value_in,
   // per-function pending registers
   input  wire logic [15:0]                      terminals_pending_in,
   input  wire logic [15:0]                      monitor_pending_in,
   input  wire logic [15:0]                      controller_pending_in,
   // host register port
   input  wire logic [hwi_pkg::HWI_ADDR_W-1:0]   host_addr_in,
   input  wire logic                             host_wr_in,
   input  wire logic                             host_rd_in,
   input  wire logic [DATA_W-1:0]                host_wdata_in,
   output logic      [DATA_W-1:0]                host_rdata_out,
   output logic                                  host_rvalid_out,
   // status out
   output logic      [hwi_pkg::HWI_TADDR_W-1:0]  term1_op_status_out,
   output logic      [hwi_pkg::HWI_TADDR_W-1:0]  term2_op_status_out,
   output logic                                  hw_irq_out
);
   import hwi_pkg::*;

   localparam int unsigned SYNC_W = 3 + 2 * HWI_TADDR_W;

   hwi_state_type          q;
   hwi_state_type          d;
   logic [SYNC_W-1:0]      sync_lvl;
   logic                   mr_sync;
   logic                   t1_en_sync;
   logic                   t2_en_sync;
   logic [HWI_TADDR_W-1:0] t1_addr_sync;
   logic [HWI_TADDR_W-1:0] t2_addr_sync;
   logic                   mr_rise;
   logic                   rd_pend;
   logic                   wr_en;
   logic                   wr_oen;
   logic                   mon_hit;
   logic                   ctl_hit;
   logic [3:0]             pend_hi;
   logic [DATA_W-1:0]      pend_word;

   generate
      if (DATA_W < HWI_MON_TAG_BIT + 1 || DATA_W > HWI_DATA_W) begin : g_chk
         $error("hwi_status_top data width cannot hold the register bits");
      end
   endgenerate

   // odd parity is good, so an even count of ones is a failure
   function automatic logic par_fail(input logic [HWI_TADDR_W-1:0] bits);
      return ~(^bits);
   endfunction : par_fail

   function automatic logic addr_is(input logic [HWI_ADDR_W-1:0] a, input logic [15:0] offs);
      return a == offs;
   endfunction : addr_is

   hwi_pin_sync #(
      .WIDTH (SYNC_W)
   ) u_pins (
      .ref_clk_in           (ref_clk_in),
      .rst_in               (rst_in),
      .pin_in               ({master_reset_n_in, term1_enable_pin_in, term2_enable_pin_in,
                              term1_addr_pins_in, term2_addr_pins_in}),
      .level_out            (sync_lvl)
   );

   assign {mr_sync, t1_en_sync, t2_en_sync, t1_addr_sync, t2_addr_sync} = sync_lvl;
   assign mr_rise = mr_sync & ~q.mr_prev;
   assign rd_pend = host_rd_in & addr_is(host_addr_in, HWI_PEND_OFFS);
   assign wr_en   = host_wr_in & addr_is(host_addr_in, HWI_EN_OFFS);
   assign wr_oen  = host_wr_in & addr_is(host_addr_in, HWI_OEN_OFFS);
   assign mon_hit = mon_tag_incr_in & (mon_tag_count_in == mon_tag_match_value_in);
   assign ctl_hit = ctl_tag_incr_in & (ctl_tag_count_in == ctl_tag_match_value_in);
   assign pend_hi = {q.mon_tag, q.ctl_tag, q.t2_fail, q.t1_fail};

   always_comb begin
      pend_word = '0;
      pend_word[HWI_MON_TAG_BIT:HWI_T1_PAR_BIT] = pend_hi;
      pend_word[HWI_TERM_SUM_BIT:HWI_CTL_SUM_BIT] = q.sums;
   end

   always_comb begin
      d         = q;
      d.mr_prev = mr_sync;
      d.rvalid  = host_rd_in;
      // reading the pending register clears the tag flags; a match in the same cycle wins
      if (rd_pend) begin
         d.mon_tag = 1'b0;
         d.ctl_tag = 1'b0;
      end
      if (mon_hit) begin
         d.mon_tag = 1'b1;
      end
      if (ctl_hit) begin
         d.ctl_tag = 1'b1;
      end
      // parity flags hold their reset value until the reset pin releases
      if (!mr_sync) begin
         d.t1_fail = HWI_PAR_FAIL_RST;
         d.t2_fail = HWI_PAR_FAIL_RST;
      end else if (mr_rise) begin
         d.t1_stat = t1_addr_sync;
         d.t2_stat = t2_addr_sync;
         d.t1_fail = t1_en_sync & par_fail(t1_addr_sync);
         d.t2_fail = t2_en_sync & par_fail(t2_addr_sync);
      end
      d.sums[HWI_TERM_SUM_BIT] = |terminals_pending_in;
      d.sums[HWI_MON_SUM_BIT]  = |monitor_pending_in;
      d.sums[HWI_CTL_SUM_BIT]  = |controller_pending_in;
      // low three bits are not stored, so they can never be written
      if (wr_en) begin
         d.en = host_wdata_in[HWI_MON_TAG_BIT:HWI_T1_PAR_BIT];
      end
      if (wr_oen) begin
         d.oen = host_wdata_in[HWI_MON_TAG_BIT:HWI_T1_PAR_BIT];
      end
      if (!host_rd_in) begin
         d.rdata = q.rdata;
      end else if (addr_is(host_addr_in, HWI_PEND_OFFS)) begin
         d.rdata = HWI_DATA_W'(pend_word);
      end else if (addr_is(host_addr_in, HWI_EN_OFFS)) begin
         d.rdata = '0;
         d.rdata[HWI_MON_TAG_BIT:HWI_T1_PAR_BIT] = q.en;
      end else if (addr_is(host_addr_in, HWI_OEN_OFFS)) begin
         d.rdata = '0;
         d.rdata[HWI_MON_TAG_BIT:HWI_T1_PAR_BIT] = q.oen;
      end else begin
         d.rdata = '0;
      end
      // summary bits have no enable, so only bits 6..3 may raise the output
      d.irq = |(pend_hi & q.en & q.oen);
   end

   always_ff @(posedge ref_clk_in or posedge rst_in) begin
      if (rst_in) begin
         q         <= '0;
         q.mon_tag <= HWI_TAG_RST;
         q.ctl_tag <= HWI_TAG_RST;
         q.t1_fail <= HWI_PAR_FAIL_RST;
         q.t2_fail <= HWI_PAR_FAIL_RST;
         q.sums    <= HWI_SUM_RST;
         q.en      <= HWI_EN_RST;
         q.oen     <= HWI_EN_RST;
      end else begin
         q <= d;
      end
   end

   assign host_rdata_out      = q.rdata[DATA_W-1:0];
   assign host_rvalid_out     = q.rvalid;
   assign term1_op_status_out = q.t1_stat;
   assign term2_op_status_out = q.t2_stat;
   assign hw_irq_out          = q.irq;

   default clocking @(posedge ref_clk_in); endclocking
   default disable iff (rst_in);

   a_mon_tag_set: assert property (mon_hit |=> q.mon_tag)
      else $error("monitor tag match did not set bit 6");
   a_ctl_tag_set: assert property (ctl_hit |=> q.ctl_tag)
      else $error("controller tag match did not set bit 5");
   a_ctl_tag_held: assert property (q.ctl_tag && !rd_pend |=> q.ctl_tag)
      else $error("controller tag flag dropped without a read");
   a_tag_held: assert property (q.mon_tag && !rd_pend |=> q.mon_tag)
      else $error("monitor tag flag dropped without a read");
   a_t2_parity: assert property (mr_rise |=> q.t2_fail == ($past(t2_en_sync) && par_fail($past(t2_addr_sync))))
      else $error("terminal 2 parity flag wrong after release");
   a_t1_parity: assert property (mr_rise |=> q.t1_fail == ($past(t1_en_sync) && par_fail($past(t1_addr_sync))))
      else $error("terminal 1 parity flag wrong after release");
   a_fail_in_reset: assert property (!mr_sync |=> q.t1_fail && q.t2_fail)
      else $error("parity flags not one while reset pin low");
   a_status_latch: assert property (mr_rise |=> term1_op_status_out == $past(t1_addr_sync))
      else $error("terminal 1 status not latched at release");
   a_status2_latch: assert property (mr_rise |=> term2_op_status_out == $past(t2_addr_sync))
      else $error("terminal 2 status not latched at release");
   a_en_write: assert property (wr_en |=> q.en == $past(host_wdata_in[HWI_MON_TAG_BIT:HWI_T1_PAR_BIT]))
      else $error("enable register write not stored");
   a_oen_write: assert property (wr_oen |=> q.oen == $past(host_wdata_in[HWI_MON_TAG_BIT:HWI_T1_PAR_BIT]))
      else $error("output enable register write not stored");
   a_en_low_zero: assert property (host_rd_in && !rd_pend && host_addr_in != HWI_PEND_OFFS
                                   |=> host_rvalid_out && host_rdata_out[2:0] == HWI_LOW_ZERO)
      else $error("enable register low bits not zero");
   a_sum_terms: assert property ((|terminals_pending_in) |=> q.sums[HWI_TERM_SUM_BIT])
      else $error("terminal summary bit wrong");
   a_sum_terms_low: assert property (!(|terminals_pending_in) |=> !q.sums[HWI_TERM_SUM_BIT])
      else $error("terminal summary bit set without pending");
   a_sum_mon: assert property ($rose(|monitor_pending_in) |=> q.sums[1] ##1 (q.sums[1] == $past(|monitor_pending_in)))
      else $error("monitor summary bit wrong");
   a_sum_ctl: assert property (!(|controller_pending_in) |=> !q.sums[0])
      else $error("controller summary bit wrong");
   a_irq_gate: assert property (hw_irq_out |-> |($past(pend_hi) & $past(q.en) & $past(q.oen)))
      else $error("interrupt output without enabled pending bit");
   a_irq_masked: assert property ((q.en == 4'h0)[*2] |-> !hw_irq_out)
      else $error("interrupt output while all enables clear");
endmodule : hwi_status_top

// ==== hdl/hwi_pkg.sv ====
// constants, field layout and state type of the hardware interrupt status block
package hwi_pkg;
   localparam int unsigned    HWI_DATA_W      = 16;
   localparam int unsigned    HWI_ADDR_W      = 16;
   localparam int unsigned    HWI_TADDR_W     = 6;
   localparam logic [15:0]    HWI_PEND_OFFS   = 16'h0006;
   localparam logic [15:0]    HWI_EN_OFFS     = 16'h0010;
   localparam logic [15:0]    HWI_OEN_OFFS    = 16'h0011;
   localparam int unsigned    HWI_MON_TAG_BIT = 6;
   localparam int unsigned    HWI_CTL_TAG_BIT = 5;
   localparam int unsigned    HWI_T2_PAR_BIT  = 4;
   localparam int unsigned    HWI_T1_PAR_BIT  = 3;
   localparam int unsigned    HWI_TERM_SUM_BIT = 2;
   localparam int unsigned    HWI_MON_SUM_BIT = 1;
   localparam int unsigned    HWI_CTL_SUM_BIT = 0;
   localparam logic           HWI_PAR_FAIL_RST = 1'b1;
   localparam logic           HWI_TAG_RST     = 1'b0;
   localparam logic [2:0]     HWI_SUM_RST     = 3'h0;
   localparam logic [3:0]     HWI_EN_RST      = 4'h0;
   localparam logic [2:0]     HWI_LOW_ZERO    = 3'h0;

   typedef struct packed {
      logic                   mon_tag;
      logic                   ctl_tag;
      logic                   t2_fail;
      logic                   t1_fail;
      logic [2:0]             sums;
      logic [3:0]             en;
      logic [3:0]             oen;
      logic                   mr_prev;
      logic [HWI_TADDR_W-1:0] t1_stat;
      logic [HWI_TADDR_W-1:0] t2_stat;
      logic [HWI_DATA_W-1:0]  rdata;
      logic                   rvalid;
      logic                   irq;
   } hwi_state_type;
endpackage : hwi_pkg

// ==== hdl/hwi_pin_sync.sv ====
// three-stage synchroniser for pin inputs, output moves when stages two and three agree
`timescale 1ns/1ps
module hwi_pin_sync #(
   parameter int unsigned WIDTH = 1
) (
   // clock and reset
   input  wire logic             ref_clk_in,
   input  wire logic             rst_in,
   // pins
   input  wire logic [WIDTH-1:0] pin_in,
   // synchronised level
   output logic      [WIDTH-1:0] level_out
);
   typedef struct packed {
      logic [WIDTH-1:0] s1;
      logic [WIDTH-1:0] s2;
      logic [WIDTH-1:0] s3;
      logic [WIDTH-1:0] lvl;
   } hwi_sync_type;

   hwi_sync_type q;
   hwi_sync_type d;

   generate
      if (WIDTH < 1) begin : g_chk
         $error("hwi_pin_sync width must be at least one");
      end
   endgenerate

   always_comb begin
      d    = q;
      d.s1 = pin_in;
      d.s2 = q.s1;
      d.s3 = q.s2;
      // per bit: only a level seen twice in a row is trusted
      d.lvl = (q.s2 & q.s3) | (q.lvl & (q.s2 ^ q.s3));
   end

   always_ff @(posedge ref_clk_in or posedge rst_in) begin
      if (rst_in) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   assign level_out = q.lvl;
endmodule : hwi_pin_sync

// ==== bench/hwi_status_top_tb.sv ====
// self-checking bench for the hardware interrupt status block
`timescale 1ns/1ps
module hwi_status_top_tb;
   import hwi_pkg::*;
   logic        ref_clk_in = 1'b0;
   logic        rst_in = 1'b1;
   logic        master_reset_n_in = 1'b0;
   logic        t1_en = 1'b0, t2_en = 1'b0;
   logic [5:0]  t1_addr = 6'h00, t2_addr = 6'h00;
   logic        mon_incr = 1'b0, ctl_incr = 1'b0;
   logic [15:0] mon_cnt = 16'h0000, mon_match = 16'h0000, ctl_cnt = 16'h0000, ctl_match = 16'h0000;
   logic [15:0] term_pend = 16'h0000, mon_pend = 16'h0000, ctl_pend = 16'h0000;
   logic [15:0] host_addr = 16'h0000, host_wdata = 16'h0000, rdata, rd_word, got_word;
   logic        host_wr = 1'b0, host_rd = 1'b0, rvalid, irq;
   logic [5:0]  st1, st2;
   logic [1:0]  exp_par;
   logic [31:0] seed_q = 32'h0000_9c35;
   int          failures = 0;
   int          check_count = 0;

   always #12.5 ref_clk_in = ~ref_clk_in;

   hwi_status_top u_dut (.ref_clk_in(ref_clk_in), .rst_in(rst_in), .master_reset_n_in(master_reset_n_in),
      .term1_enable_pin_in(t1_en), .term2_enable_pin_in(t2_en), .term1_addr_pins_in(t1_addr),
      .term2_addr_pins_in(t2_addr), .mon_tag_incr_in(mon_incr), .mon_tag_count_in(mon_cnt),
      .mon_tag_match_value_in(mon_match), .ctl_tag_incr_in(ctl_incr), .ctl_tag_count_in(ctl_cnt),
      .ctl_tag_match_value_in(ctl_match), .terminals_pending_in(term_pend), .monitor_pending_in(mon_pend),
      .controller_pending_in(ctl_pend), .host_addr_in(host_addr), .host_wr_in(host_wr), .host_rd_in(host_rd),
      .host_wdata_in(host_wdata), .host_rdata_out(rdata), .host_rvalid_out(rvalid),
      .term1_op_status_out(st1), .term2_op_status_out(st2), .hw_irq_out(irq));

   function automatic logic [31:0] xorshift();
      seed_q = seed_q ^ (seed_q << 13);
      seed_q = seed_q ^ (seed_q >> 17);
      seed_q = seed_q ^ (seed_q << 5);
      return seed_q;
   endfunction : xorshift

   // odd parity expected; a disabled terminal reports no failure once the reset pin releases
   function automatic logic par_fail(input logic en, input logic [5:0] a);
      return en & ~(^a);
   endfunction : par_fail

   task automatic complete_run();
      if (failures == 0 && check_count > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : complete_run

   task automatic chk_word(input logic [15:0] got, input logic [15:0] exp, input string msg);
      check_count++;
      if (got !== exp) begin
         failures++;
         $display("BAD %0t %s got %h exp %h", $time, msg, got, exp);
      end
   endtask : chk_word

   task automatic chk_bit(input logic got, input logic exp, input string msg);
      check_count++;
      if (got !== exp) begin
         failures++;
         $display("BAD %0t %s got %b exp %b", $time, msg, got, exp);
      end
   endtask : chk_bit

   task automatic host_read(input logic [15:0] a, output logic [15:0] d);
      @(posedge ref_clk_in) host_addr <= a;
      host_rd <= 1'b1;
      @(posedge ref_clk_in) host_rd <= 1'b0;
      #1;
      chk_bit(rvalid, 1'b1, "read strobe unanswered");
      d = rdata;
   endtask : host_read

   task automatic host_write(input logic [15:0] a, input logic [15:0] d);
      @(posedge ref_clk_in) host_addr <= a;
      host_wdata <= d;
      host_wr <= 1'b1;
      @(posedge ref_clk_in) host_wr <= 1'b0;
   endtask : host_write

   // the pin must settle through its synchroniser, so give it generous slack
   task automatic mr_cycle(input logic e1, input logic e2, input logic [5:0] a1, input logic [5:0] a2);
      @(posedge ref_clk_in) master_reset_n_in <= 1'b0;
      t1_en <= e1;
      t2_en <= e2;
      t1_addr <= a1;
      t2_addr <= a2;
      repeat (8) @(posedge ref_clk_in);
      host_read(HWI_PEND_OFFS, rd_word);
      chk_word(rd_word & 16'h0018, 16'h0018, "parity flags in reset");
      @(posedge ref_clk_in) master_reset_n_in <= 1'b1;
      repeat (8) @(posedge ref_clk_in);
      chk_word({4'h0, st1, st2}, {4'h0, a1, a2}, "latched address");
      exp_par = {par_fail(e2, a2), par_fail(e1, a1)};
      host_read(HWI_PEND_OFFS, rd_word);
      chk_word(rd_word & 16'h0018, {11'h000, exp_par, 3'h0}, "parity flags");
   endtask : mr_cycle

   task automatic tag_pulse(input logic mon, input logic hit);
      logic [15:0] m;
      m = 16'(xorshift());
      @(posedge ref_clk_in);
      if (mon) begin
         mon_match <= m;
         mon_cnt <= hit ? m : m ^ 16'h0001;
         mon_incr <= 1'b1;
      end else begin
         ctl_match <= m;
         ctl_cnt <= hit ? m : m ^ 16'h8000;
         ctl_incr <= 1'b1;
      end
      @(posedge ref_clk_in) mon_incr <= 1'b0;
      ctl_incr <= 1'b0;
   endtask : tag_pulse

   initial begin
      repeat (100000) @(posedge ref_clk_in);
      failures++;
      complete_run();
   end

   initial begin
      repeat (2) @(posedge ref_clk_in);
      rst_in <= 1'b0;
      host_read(HWI_PEND_OFFS, rd_word);
      chk_word(rd_word, 16'h0018, "pending after reset");
      mr_cycle(1'b1, 1'b1, 6'h03, 6'h07);
      mr_cycle(1'b0, 1'b0, 6'h03, 6'h0f);
      for (int i = 0; i < 3; i++) mr_cycle(1'(xorshift()), 1'b1, 6'(xorshift()), 6'(xorshift()));
      for (int i = 0; i < 4; i++) begin
         rd_word = 16'(xorshift());
         host_write(HWI_EN_OFFS, rd_word);
         host_write(HWI_OEN_OFFS, ~rd_word);
         host_read(HWI_EN_OFFS, got_word);
         chk_word(got_word, rd_word & 16'h0078, "enable readback");
         host_read(HWI_OEN_OFFS, got_word);
         chk_word(got_word, ~rd_word & 16'h0078, "output enable readback");
      end
      host_write(HWI_PEND_OFFS, 16'hffff);
      host_write(16'h0012, 16'hffff);
      host_read(16'h0012, rd_word);
      chk_word(rd_word, 16'h0000, "unmapped read");
      host_read(HWI_PEND_OFFS, rd_word);
      chk_word(rd_word, {11'h000, exp_par, 3'h0}, "pending write ignored");
      for (int i = 0; i < 6; i++) begin
         @(posedge ref_clk_in) term_pend <= (i == 0) ? 16'h0000 : 16'(xorshift()) & {16{i[0]}};
         mon_pend <= (i == 0) ? 16'h0000 : 16'h0001 << (xorshift() % 16) & {16{i[1]}};
         ctl_pend <= (i == 5) ? 16'h8000 : 16'(xorshift()) & {16{i[2]}};
         repeat (2) @(posedge ref_clk_in);
         host_read(HWI_PEND_OFFS, rd_word);
         chk_word(rd_word & 16'h0007, {13'h0000, |term_pend, |mon_pend, |ctl_pend}, "summary bits");
      end
      @(posedge ref_clk_in) term_pend <= 16'h0000;
      mon_pend <= 16'h0000;
      ctl_pend <= 16'h0000;
      for (int i = 0; i < 6; i++) begin
         tag_pulse(1'b1, i[0]);
         tag_pulse(1'b0, ~i[0]);
         host_read(HWI_PEND_OFFS, rd_word);
         chk_word(rd_word, {9'h000, i[0], ~i[0], exp_par, 3'h0}, "tag match bits");
         host_read(HWI_PEND_OFFS, rd_word);
         chk_word(rd_word, {11'h000, exp_par, 3'h0}, "tag bits after read");
      end
      host_write(HWI_EN_OFFS, 16'h0040);
      host_write(HWI_OEN_OFFS, 16'h0060);
      tag_pulse(1'b0, 1'b1);
      repeat (3) @(posedge ref_clk_in);
      chk_bit(irq, 1'b0, "irq without enable");
      tag_pulse(1'b1, 1'b1);
      repeat (3) @(posedge ref_clk_in);
      chk_bit(irq, 1'b1, "irq enabled match");
      host_read(HWI_PEND_OFFS, rd_word);
      host_write(HWI_OEN_OFFS, 16'h0020);
      tag_pulse(1'b1, 1'b1);
      repeat (3) @(posedge ref_clk_in);
      chk_bit(irq, 1'b0, "irq without output enable");
      complete_run();
   end
endmodule : hwi_status_top_tb
